// [common/odc_pkg.sv]
package odc_pkg;

  // ----------------------------------------------------------------
  // core data space map
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_REG_ADDR  = 8'he8;
  localparam logic [7:0] SYNC_POLL_ADDR = 8'he4;
  localparam logic [7:0] BANK_ADDR      = 8'hed;
  localparam logic [7:0] GAP_ADDR       = 8'h13;
  localparam logic [7:0] BACKDROP_ADDR  = 8'h14;
  localparam logic [7:0] MASTER_ADDR    = 8'h17;
  localparam logic [7:0] PAGED_TOP      = 8'h3f;
  localparam logic [7:0] LINE5_TOP      = 8'h0f;
  localparam int         PAGE5_BIT      = 5;
  localparam int         PAGE6_BIT      = 6;
  localparam int         SYNC_POLL_BIT  = 4;

  // ----------------------------------------------------------------
  // display geometry
  // ----------------------------------------------------------------
  localparam int         LINES          = 5;
  localparam int         COLS           = 16;
  localparam int         ENTRIES        = 80;
  localparam int         ENTRY_W        = 7;
  localparam logic [8:0] BASE_WIDTH     = 9'h006;
  localparam logic [6:0] BASE_HEIGHT    = 7'h12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GS_HI_BIT      = 7;
  localparam int GS_LO_BIT      = 6;
  localparam int GAP_VAL_HI     = 5;
  localparam int FMT_SIZE_BIT   = 6;
  localparam int FMT_LGAP_BIT   = 5;
  localparam int SPACE_MARK_BIT = 6;
  localparam int SPACE_GAP_BIT  = 5;
  localparam int WORD_ON_BIT    = 4;
  localparam int PICK_BIT       = 3;
  localparam int HUE_HI         = 2;
  localparam int BD_R1 = 7;
  localparam int BD_R0 = 6;
  localparam int BD_G1 = 5;
  localparam int BD_G0 = 4;
  localparam int BD_B1 = 3;
  localparam int BD_B0 = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       RESET_MASTER = 1'b0;
  localparam logic [1:0] RESET_PAGE   = 2'h0;

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_ARM   = 4'b0010,
    ST_FRAME = 4'b0100,
    ST_DONE  = 4'b1000
  } odc_fsm_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odc_bus_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic blank;
  } odc_video_t;

  // size multiplier 1..4 from global size pair and the line's size bit
  function automatic logic [2:0] size_scale(input logic hi, input logic lo, input logic s);
    case ({hi, lo, s})
      3'h1, 3'h4, 3'h6: size_scale = 3'h2;
      3'h3, 3'h5:       size_scale = 3'h3;
      3'h7:             size_scale = 3'h4;
      default:          size_scale = 3'h1;
    endcase
  endfunction

  function automatic logic [8:0] width_dots(input logic [2:0] scale);
    width_dots = 9'(BASE_WIDTH * 9'(scale));
  endfunction

  // extra word gap in dots: (1 + value) dots per size step
  function automatic logic [8:0] gap_dots(input logic [2:0] scale, input logic [5:0] val);
    gap_dots = 9'((9'(val) + 9'h001) * 9'(scale));
  endfunction

  function automatic logic [6:0] row_lines(input logic [2:0] scale);
    row_lines = 7'(BASE_HEIGHT * 7'(scale));
  endfunction

  function automatic logic [2:0] backdrop_hue(input logic pick, input logic [7:0] backdrop_ctrl);
    backdrop_hue = pick ? {backdrop_ctrl[BD_R1], backdrop_ctrl[BD_G1], backdrop_ctrl[BD_B1]}
                        : {backdrop_ctrl[BD_R0], backdrop_ctrl[BD_G0], backdrop_ctrl[BD_B0]};
  endfunction

endpackage

// [core/odc_display_ctrl.sv]
// Behaviour
// - size bits pick height 18-72H, width 6-24 dots
// - word-gap flag adds programmed dots after space
// - base extra gap is (1 + value) dots
// - extra gap scales by 1, 2, 3 or 4
// - two backdrops, word picks one by flag
// - backdrop hue is plain red/green/blue bits
// - backdrop drawn only when its enable set
// - bank bit, zero lower, locked while enabled
// - display memory writable only while disabled
// - first entry of line is hidden format
// - space sets word attributes, else glyph index
// - eighty seven-bit entries, five lines of sixteen
// - page 5 lines 1-4, page 6 rest
// - all locations write-only, reads return zero except the sync poll
// - master enable writable at any time in page 6, others locked
// - oscillator starts at next vertical sync
// - clearing master enable stops oscillator at once
// - late enable waits a whole frame
// - inverted vertical sync readable at bit 4
// - syncs lock display, four video outputs
// - trailing space in size 0 with word off and its backdrop on draws bar
// - master enable off blanks whole display
module odc_display_ctrl (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                ce_in,
  input  wire odc_pkg::odc_bus_t   bus_in,
  input  wire logic                vsync_in,
  input  wire logic                hsync_in,
  output logic [7:0]               rd_data_out,
  output odc_pkg::odc_video_t      video_out,
  output logic                     osc_run_out,
  output logic                     bank_choice_out,
  output logic [5:0]               glyph_index_out,
  output logic                     glyph_valid_out
);
  import odc_pkg::*;

  typedef struct packed {
    logic [1:0]                          page;
    logic                                master_on;
    logic                                bank_choice;
    logic [7:0]                          gap_reg;
    logic [7:0]                          backdrop;
    logic [ENTRIES-1:0][ENTRY_W-1:0]     ram;
    odc_fsm_t                            fsm;
    logic                                osc_run;
    logic                                half;
    logic                                active;
    logic [2:0]                          row;
    logic [6:0]                          row_line;
    logic [4:0]                          col;
    logic [8:0]                          dot_cnt;
    logic [2:0]                          scale;
    logic                                fmt_s;
    logic                                line_gap;
    logic                                word_on;
    logic                                pick;
    logic [2:0]                          hue;
    logic                                is_char;
    logic                                is_bar;
    logic                                last_space;
    logic [5:0]                          glyph;
    logic [7:0]                          rd_data;
    odc_video_t                          video;
    logic                                glyph_valid;
  } odc_state_t;

  odc_state_t st;
  odc_state_t nx;
  logic [1:0] rise;
  logic       vs_rise;
  logic       hs_rise;
  logic [6:0] entry;
  logic [6:0] wr_index;
  logic [8:0] cell_dots;
  logic       wr_open;
  logic       page5;
  logic       page6;
  logic       dot_tick;
  logic       bar_due;

  odc_edge_detect #(
    .W (2)
  ) u_sync_edge (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .level_in ({vsync_in, hsync_in}),
    .rise_out (rise)
  );

  assign vs_rise = rise[1];
  assign hs_rise = rise[0];

  always_comb
  begin
    nx        = st;
    entry     = st.ram[{st.row, st.col[3:0]}];
    cell_dots = width_dots(st.scale);
    page5     = st.page[0];
    page6     = st.page[1] & ~st.page[0];
    wr_index  = page5 ? {1'b0, bus_in.addr[5:0]} : {3'h4, bus_in.addr[3:0]};
    wr_open   = !st.master_on && !st.osc_run;
    dot_tick  = st.osc_run & st.half;
    bar_due   = st.last_space && !st.fmt_s && !st.word_on
                && st.backdrop[st.pick];

    // ----------------------------------------------------------------
    // core access
    // ----------------------------------------------------------------
    // everything here is write-only; only the sync poll answers a read
    nx.rd_data = 8'h00;
    if (bus_in.rd && bus_in.addr == SYNC_POLL_ADDR)
    begin
      nx.rd_data[SYNC_POLL_BIT] = ~vsync_in;
    end
    if (bus_in.wr)
    begin
      // the page register belongs to the core; we only follow its writes
      if (bus_in.addr == PAGE_REG_ADDR)
      begin
        nx.page = {bus_in.wdata[PAGE6_BIT], bus_in.wdata[PAGE5_BIT]};
      end
      else if (page6 && bus_in.addr == MASTER_ADDR)
      begin
        nx.master_on = bus_in.wdata[0];
      end
      else if (!wr_open)
      begin
        nx.page = st.page;
      end
      else if (bus_in.addr == BANK_ADDR)
      begin
        nx.bank_choice = bus_in.wdata[0];
      end
      else if (page5 && bus_in.addr <= PAGED_TOP)
      begin
        nx.ram[wr_index] = bus_in.wdata[ENTRY_W-1:0];
      end
      else if (page6 && bus_in.addr <= LINE5_TOP)
      begin
        nx.ram[wr_index] = bus_in.wdata[ENTRY_W-1:0];
      end
      else if (page6 && bus_in.addr == GAP_ADDR)
      begin
        nx.gap_reg = bus_in.wdata;
      end
      else if (page6 && bus_in.addr == BACKDROP_ADDR)
      begin
        nx.backdrop = bus_in.wdata;
      end
    end

    // ----------------------------------------------------------------
    // oscillator control and frame sequencing
    // ----------------------------------------------------------------
    nx.half = st.osc_run ? ~st.half : 1'b0;
    case (st.fsm)
      ST_OFF:
      begin
        if (st.master_on)
        begin
          nx.fsm = ST_ARM;
        end
      end
      ST_ARM:
      begin
        // a set after flyback simply waits for the next frame's sync
        if (vs_rise)
        begin
          nx.fsm      = ST_FRAME;
          nx.osc_run  = 1'b1;
          nx.row      = 3'h0;
          nx.row_line = 7'h00;
          nx.active   = 1'b0;
        end
      end
      ST_FRAME, ST_DONE:
      begin
        if (vs_rise)
        begin
          nx.fsm      = ST_FRAME;
          nx.row      = 3'h0;
          nx.row_line = 7'h00;
          nx.active   = 1'b0;
        end
        else if (st.fsm == ST_FRAME && hs_rise)
        begin
          nx.active  = 1'b1;
          nx.col     = 5'h00;
          nx.dot_cnt = 9'h000;
        end
        else if (st.active && st.dot_cnt != 9'h000)
        begin
          if (dot_tick)
          begin
            nx.dot_cnt = st.dot_cnt - 9'h001;
          end
        end
        else if (st.active && st.col == 5'h00)
        begin
          // hidden format entry: no dots, sets the line and first word
          nx.fmt_s      = entry[FMT_SIZE_BIT];
          nx.line_gap   = entry[FMT_LGAP_BIT];
          nx.scale      = size_scale(st.gap_reg[GS_HI_BIT], st.gap_reg[GS_LO_BIT],
                                     entry[FMT_SIZE_BIT]);
          nx.word_on    = entry[WORD_ON_BIT];
          nx.pick       = entry[PICK_BIT];
          nx.hue        = entry[HUE_HI:0];
          nx.last_space = 1'b0;
          nx.col        = 5'h01;
        end
        else if (st.active && st.col < 5'(COLS))
        begin
          nx.col     = st.col + 5'h01;
          nx.dot_cnt = cell_dots;
          // restart the dot phase so every cell lasts exactly two clocks per dot
          nx.half    = 1'b0;
          nx.is_bar  = 1'b0;
          if (entry[SPACE_MARK_BIT])
          begin
            nx.is_char    = 1'b0;
            nx.last_space = 1'b1;
            nx.word_on    = entry[WORD_ON_BIT];
            nx.pick       = entry[PICK_BIT];
            nx.hue        = entry[HUE_HI:0];
            if (entry[SPACE_GAP_BIT])
            begin
              nx.dot_cnt = cell_dots + gap_dots(st.scale, st.gap_reg[GAP_VAL_HI:0]);
            end
          end
          else
          begin
            nx.is_char    = 1'b1;
            nx.last_space = 1'b0;
            nx.glyph      = entry[5:0];
          end
        end
        else if (st.active && st.col == 5'(COLS) && bar_due)
        begin
          nx.is_bar  = 1'b1;
          nx.is_char = 1'b0;
          nx.dot_cnt = cell_dots;
          nx.half    = 1'b0;
          nx.col     = st.col + 5'h01;
        end
        else if (st.active)
        begin
          nx.active = 1'b0;
          nx.is_bar = 1'b0;
          if (st.row_line + 7'h01 >= row_lines(st.scale))
          begin
            nx.row_line = 7'h00;
            nx.row      = st.row + 3'h1;
            if (st.row == 3'(LINES - 1))
            begin
              nx.fsm = ST_DONE;
            end
          end
          else
          begin
            nx.row_line = st.row_line + 7'h01;
          end
        end
      end
      default:
      begin
        nx.fsm = ST_OFF;
      end
    endcase

    // clearing the enable kills the oscillator without waiting for sync
    if (!nx.master_on)
    begin
      nx.fsm     = ST_OFF;
      nx.osc_run = 1'b0;
      nx.active  = 1'b0;
      nx.dot_cnt = 9'h000;
    end

    // ----------------------------------------------------------------
    // pixel outputs
    // ----------------------------------------------------------------
    // glyph bitmap lives outside; the character cell shows the word hue
    nx.video       = '0;
    nx.glyph_valid = 1'b0;
    if (st.master_on && st.osc_run && st.active && st.dot_cnt != 9'h000)
    begin
      if (st.is_bar)
      begin
        nx.video = {backdrop_hue(st.pick, st.backdrop), 1'b1};
      end
      else if (st.word_on && st.is_char)
      begin
        nx.video       = {st.hue, 1'b1};
        nx.glyph_valid = 1'b1;
      end
      else if (st.word_on && st.backdrop[st.pick])
      begin
        nx.video = {backdrop_hue(st.pick, st.backdrop), 1'b1};
      end
    end
  end

  // ram and configuration keep no reset on purpose in the device, but a
  // known zero keeps simulation clean and costs nothing here
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st           <= '0;
      st.fsm       <= ST_OFF;
      st.master_on <= RESET_MASTER;
      st.page      <= RESET_PAGE;
    end
    else if (ce_in)
    begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_out     = st.rd_data;
  assign video_out       = st.video;
  assign osc_run_out     = st.osc_run;
  assign bank_choice_out = st.bank_choice;
  assign glyph_index_out = st.glyph;
  assign glyph_valid_out = st.glyph_valid;

endmodule

// [core/odc_edge_detect.sv]
module odc_edge_detect #(
  parameter int W = 2
)(
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);

  logic [W-1:0] prev;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      prev <= '0;
    else if (ce_in)
      prev <= level_in;
  end

  // gated by the enable so a frozen block never sees a stale edge
  assign rise_out = level_in & ~prev & {W{ce_in}};

endmodule

// [dv/odc_display_ctrl_monitor.sv]
module odc_display_ctrl_monitor (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                ce_in,
  input  wire odc_pkg::odc_bus_t   bus_in,
  input  wire logic                vsync_in,
  input  wire logic                hsync_in,
  input  wire logic [7:0]          rd_data_out,
  input  wire odc_pkg::odc_video_t video_out,
  input  wire logic                osc_run_out,
  input  wire logic                bank_choice_out,
  input  wire logic [5:0]          glyph_index_out,
  input  wire logic                glyph_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import odc_pkg::*;

  // --------------------------------
  // shadow of page and master enable
  // --------------------------------
  logic page6_q;
  logic master_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      page6_q  <= 1'b0;
      master_q <= 1'b0;
    end
    else if (ce_in && bus_in.wr)
    begin
      if (bus_in.addr == PAGE_REG_ADDR)
        page6_q <= bus_in.wdata[PAGE6_BIT] && !bus_in.wdata[PAGE5_BIT];
      if (bus_in.addr == MASTER_ADDR && page6_q)
        master_q <= bus_in.wdata[0];
    end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_master_clear;
    ce_in && bus_in.wr && bus_in.addr == MASTER_ADDR && page6_q && !bus_in.wdata[0];
  endsequence

  sequence s_bank_write;
    ce_in && bus_in.wr && bus_in.addr == BANK_ADDR && !master_q && !osc_run_out;
  endsequence

  // --------------------------------
  // properties
  // --------------------------------
  start_on_vsync_a: assert property ($rose(osc_run_out) |-> master_q && $past(vsync_in) && !$past(vsync_in, 2))
    else $error("oscillator started without an armed vsync edge");
  stop_at_once_a: assert property (s_master_clear |=> !osc_run_out)
    else $error("oscillator still running after master clear");
  poll_inverted_a: assert property (ce_in && bus_in.rd && bus_in.addr == SYNC_POLL_ADDR
    |=> rd_data_out == {3'h0, !$past(vsync_in), 4'h0}) else $error("sync poll value wrong");
  write_only_a: assert property (ce_in && !(bus_in.rd && bus_in.addr == SYNC_POLL_ADDR) |=> rd_data_out == 8'h00)
    else $error("write-only location returned data");
  bank_take_a: assert property (s_bank_write |=> bank_choice_out == $past(bus_in.wdata[0]))
    else $error("bank choice not taken");
  bank_lock_a: assert property ($past(osc_run_out || master_q) |-> $stable(bank_choice_out))
    else $error("bank choice changed while display on");
  blank_when_off_a: assert property (!osc_run_out [*3] |-> !video_out.blank && !glyph_valid_out)
    else $error("overlay shown while display off");
  glyph_needs_osc_a: assert property (glyph_valid_out |-> $past(osc_run_out))
    else $error("glyph cell without running oscillator");
endmodule

bind odc_display_ctrl odc_display_ctrl_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .bus_in(bus_in), .vsync_in(vsync_in), .hsync_in(hsync_in), .rd_data_out(rd_data_out), .video_out(video_out),
  .osc_run_out(osc_run_out), .bank_choice_out(bank_choice_out), .glyph_index_out(glyph_index_out),
  .glyph_valid_out(glyph_valid_out));

// [dv/odc_display_ctrl_tb_top.sv]
module odc_display_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import odc_pkg::*;

`define ODC_CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("Error at %0t: value %0h expected %0h", $time, (got), (exp)); \
    end \
  end

  logic       clk = 1'b0;
  logic       rst_b;
  logic       ce;
  odc_bus_t   bus;
  logic       vsync;
  logic       hsync;
  logic [7:0] rd_data;
  odc_video_t video;
  logic       osc_run;
  logic       bank;
  logic [5:0] glyph_idx;
  logic       glyph_valid;
  int         bad_count  = 0;
  int         num_checks = 0;
  int         cycles     = 0;

  initial
    forever #20 clk = ~clk;

  odc_display_ctrl uut (.clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .bus_in(bus), .vsync_in(vsync),
    .hsync_in(hsync), .rd_data_out(rd_data), .video_out(video), .osc_run_out(osc_run),
    .bank_choice_out(bank), .glyph_index_out(glyph_idx), .glyph_valid_out(glyph_valid));

  odc_tv_model u_tv (.clk_in(clk), .video_in(video), .glyph_valid_in(glyph_valid), .vsync_out(vsync),
    .hsync_out(hsync));

  // --------------------------------
  // core bus cycles
  // --------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    bus.rd = 1'b0;
    d = rd_data;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_poll();
    logic [7:0] d;
    u_tv.set_vsync(1'b1);
    rd(SYNC_POLL_ADDR, d);
    `ODC_CHECK(d, 8'h00)
    u_tv.set_vsync(1'b0);
    rd(SYNC_POLL_ADDR, d);
    `ODC_CHECK(d, 8'h10)
    rd(BACKDROP_ADDR, d);
    `ODC_CHECK(d, 8'h00)
    rd(8'h90, d);
    `ODC_CHECK(d, 8'h00)
  endtask

  // clear, rewrite and re-enable as software would inside flyback
  task automatic t_frame(input logic [7:0] gap, input logic szb, input logic [7:0] bd, input int sc,
                         input logic [3:0] look, input logic [3:0] mask);
    int exp_gap;
    exp_gap = (7 + int'(gap[5:0])) * sc * 2;
    wr(MASTER_ADDR, 8'h00);
    `ODC_CHECK(osc_run, 1'b0)
    wr(GAP_ADDR, gap);
    wr(BACKDROP_ADDR, bd);
    wr(PAGE_REG_ADDR, 8'h20);
    wr(8'h00, {1'b0, szb, 6'h11});
    for (int c = 1; c < COLS; c++)
      wr(8'(c), c == 2 ? 8'h7a : 8'h09);
    wr(PAGE_REG_ADDR, 8'h40);
    wr(MASTER_ADDR, 8'h01);
    repeat (20) @(negedge clk);
    `ODC_CHECK(osc_run, 1'b0)
    u_tv.pulse(1'b1);
    repeat (2) @(negedge clk);
    `ODC_CHECK(osc_run, 1'b1)
    u_tv.clear();
    u_tv.pulse(1'b0);
    repeat (1600) @(negedge clk);
    `ODC_CHECK(u_tv.hi_count, 14 * 12 * sc)
    `ODC_CHECK(u_tv.gap_len >= exp_gap && u_tv.gap_len <= exp_gap + 2, 1'b1)
    `ODC_CHECK(u_tv.gap_look & mask, look & mask)
    `ODC_CHECK(glyph_idx, 6'h09)
  endtask

  // trailing space, size 0, word off but its backdrop on: bar in backdrop hue
  task automatic t_bar();
    wr(MASTER_ADDR, 8'h00);
    wr(GAP_ADDR, 8'h00);
    wr(BACKDROP_ADDR, 8'h2a);
    wr(PAGE_REG_ADDR, 8'h20);
    wr(8'h00, 8'h11);
    wr(8'h0f, 8'h48);
    wr(PAGE_REG_ADDR, 8'h40);
    wr(MASTER_ADDR, 8'h01);
    u_tv.pulse(1'b1);
    u_tv.clear();
    u_tv.pulse(1'b0);
    repeat (400) @(negedge clk);
    `ODC_CHECK(u_tv.last_lit, 4'b0111)
  endtask

  task automatic t_bank();
    wr(BANK_ADDR, 8'h01);
    `ODC_CHECK(bank, 1'b0)
    wr(MASTER_ADDR, 8'h00);
    `ODC_CHECK(osc_run, 1'b0)
    wr(BANK_ADDR, 8'h01);
    `ODC_CHECK(bank, 1'b1)
    wr(BANK_ADDR, 8'h00);
    `ODC_CHECK(bank, 1'b0)
    // a frozen block must not take an otherwise legal write
    ce = 1'b0;
    wr(BANK_ADDR, 8'h01);
    `ODC_CHECK(bank, 1'b0)
    ce = 1'b1;
  endtask

  // --------------------------------
  // run control
  // --------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ceiling sized at about three times the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    bus   = '0;
    ce    = 1'b1;
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    wr(PAGE_REG_ADDR, 8'h40);
    t_poll();
    t_frame(8'h00, 1'b0, 8'h2a, 1, 4'b0111, 4'hf);
    t_frame(8'h3f, 1'b1, 8'hd6, 2, 4'b1001, 4'hf);
    t_frame(8'h45, 1'b1, 8'hd4, 3, 4'b0000, 4'h1);
    t_frame(8'hc5, 1'b1, 8'h2a, 4, 4'b0111, 4'hf);
    t_bar();
    t_bank();
    final_report();
  end
endmodule

// [dv/odc_tv_model.sv]
module odc_tv_model (
  input  wire logic                clk_in,
  input  wire odc_pkg::odc_video_t video_in,
  input  wire logic                glyph_valid_in,
  output logic                     vsync_out,
  output logic                     hsync_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import odc_pkg::*;

  int         hi_count = 0;
  int         lo_run   = 0;
  int         gap_len  = 0;
  logic [3:0] gap_look = 4'h0;
  logic [3:0] last_lit = 4'h0;
  bit         looked   = 1'b0;

  initial
  begin
    vsync_out = 1'b0;
    hsync_out = 1'b0;
  end

  // --------------------------------
  // sync generation, two clocks wide
  // --------------------------------
  task automatic set_vsync(input logic v);
    @(negedge clk_in);
    vsync_out = v;
  endtask

  task automatic pulse(input bit vert);
    @(negedge clk_in);
    if (vert)
      vsync_out = 1'b1;
    else
      hsync_out = 1'b1;
    repeat (2) @(negedge clk_in);
    vsync_out = 1'b0;
    hsync_out = 1'b0;
  endtask

  task automatic clear();
    hi_count = 0;
    lo_run   = 0;
    gap_len  = 0;
    looked   = 1'b0;
    last_lit = 4'h0;
  endtask

  // --------------------------------
  // overlay capture
  // --------------------------------
  // the longest dark run between glyphs is the word gap; single load cycles are shorter
  // the last lit cell of a line tells whether an end-of-line bar was drawn
  always @(posedge clk_in)
  begin
    if (video_in.blank)
      last_lit = video_in;
    if (glyph_valid_in)
    begin
      hi_count++;
      if (lo_run > gap_len)
        gap_len = lo_run;
      lo_run = 0;
    end
    else if (hi_count > 0)
    begin
      lo_run++;
      if (lo_run == 4 && !looked)
      begin
        gap_look = video_in;
        looked   = 1'b1;
      end
    end
  end
endmodule
